// *** core/dual_pwm_top.sv ***
// Purpose: two generators on a trimmed base tick with channel mapping
// Assumes: parallel inputs come from pins and are synchronised here
// Notes: reserved trim code runs at nominal rate
module dual_pwm_top
	import pwm_pkg::*;
#(
	// Nominal tick length in mclk cycles, follows the clock rate
	parameter int TICK_NOM = TICK_NOM_CYC
)
(
	input  wire logic                   mclk,
	input  wire logic                   nrst,
	input  wire logic [3:0]             baseTickTrim,
	input  wire logic [DUTY_W-1:0]      duty0,
	input  wire logic [1:0]             periodDiv0,
	input  wire logic [DUTY_W-1:0]      duty1,
	input  wire logic [1:0]             periodDiv1,
	input  wire logic [2*NUM_CHAN-1:0]  chanSource,
	input  wire logic [NUM_CHAN-1:0]    chanPwmEnable,
	input  wire logic [NUM_CHAN-1:0]    chanDirect,
	input  wire logic [1:0]             parallelIn,
	output logic [NUM_CHAN-1:0]         chanOut,
	output logic [NUM_GEN-1:0]          genOut,
	output logic                        baseTick
);
	logic [1:0]   inMeta;
	logic [1:0]   inSync;
	logic [15:0]  tickCount;
	logic [15:0]  tickPeriod;
	logic         tick;
	logic [NUM_GEN-1:0] genPwm;
	logic [3:0]   sources;
	logic [NUM_CHAN-1:0] next_chanOut;

	assign tickPeriod = trim_period(baseTickTrim, TICK_NOM);
	assign tick       = (tickCount >= tickPeriod - 16'h0001);
	assign sources    = {inSync, genPwm};

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			inMeta    <= 2'h0;
			inSync    <= 2'h0;
			tickCount <= 16'h0000;
			baseTick  <= 1'b0;
			genOut    <= '0;
			chanOut   <= '0;
		end else begin
			inMeta    <= parallelIn;
			inSync    <= inMeta;
			tickCount <= tick ? 16'h0000 : tickCount + 16'h0001;
			baseTick  <= tick;
			genOut    <= genPwm;
			chanOut   <= next_chanOut;
		end
	end

	// Each generator keeps its own settings
	pwm_gen gen0 (
		.mclk                (mclk),
		.nrst                (nrst),
		.tick                (tick),
		.dutySetting         (duty0),
		.periodDividerSelect (periodDiv0),
		.pwmOut              (genPwm[0]),
		.periodStart         ()
	);
	pwm_gen gen1 (
		.mclk                (mclk),
		.nrst                (nrst),
		.tick                (tick),
		.dutySetting         (duty1),
		.periodDividerSelect (periodDiv1),
		.pwmOut              (genPwm[1]),
		.periodStart         ()
	);

	genvar c;
	generate
		for (c = 0; c < NUM_CHAN; c++) begin : g_map
			assign next_chanOut[c] = chanPwmEnable[c] ?
				sources[chanSource[2*c +: 2]] : chanDirect[c];
		end
	endgenerate

	map_follow_a: assert property (@(posedge mclk) disable iff (!nrst)
		(chanPwmEnable[0] && chanSource[1:0] == SRC_GEN1)
		|=> chanOut[0] == $past(genPwm[1])) else $error("map not followed");
	tick_space_a: assert property (@(posedge mclk) disable iff (!nrst)
		tick |=> !tick) else $error("base tick too close");
	trim_nom_a: assert property (@(posedge mclk) disable iff (!nrst)
		(baseTickTrim == TRIM_NOMINAL) |-> tickPeriod == 16'(TICK_NOM))
		else $error("nominal trim wrong");
	in_src_a: assert property (@(posedge mclk) disable iff (!nrst)
		(chanPwmEnable[1] && chanSource[3:2] == SRC_IN0)
		|=> chanOut[1] == $past(inSync[0])) else $error("input source wrong");
endmodule

// *** core/pwm_pkg.sv ***
// Purpose: constants for the dual generator and channel mapping block
// Assumes: one clock mclk at 125 MHz, synchronous active-low reset
// Notes:
// Notes on behaviour
// - The base tick rate is trimmed by a 4-bit code, 0000 reserved, 1000 nominal, lower codes slower by 37.2% to 5.8%, higher codes faster by 4.3% to 40.0%.
// - Each generator holds an 8-bit duty setting giving steps of 1/256 of the period.
// - A new duty setting takes effect only at the start of the next period, also when the old one was 0% or 100%.
// - Duty setting all ones gives 255/256 high with one step low per period.
// - Period divider select 11 holds the generator output permanently active.
// - Period divider select 00, 01 and 10 give base tick divided by 1024, 512 and 256.
// - Each output channel can follow either generator independently of the others.
// - Two generators and two parallel input pins act as four independent sources for channels.
// - There are two independent generators, each with its own duty and period settings.
// - Both generators count from a common base tick whose rate is set by the trim code.
package pwm_pkg;
	localparam int          NUM_GEN       = 2;
	localparam int          NUM_CHAN      = 8;
	localparam int          DUTY_W        = 8;
	localparam int          CNT_W         = 10;
	localparam logic [1:0]  DIV_1024      = 2'h0;
	localparam logic [1:0]  DIV_512       = 2'h1;
	localparam logic [1:0]  DIV_256       = 2'h2;
	localparam logic [1:0]  DIV_FULL_ON   = 2'h3;
	localparam logic [3:0]  TRIM_RESERVED = 4'h0;
	localparam logic [3:0]  TRIM_NOMINAL  = 4'h8;
	localparam logic [DUTY_W-1:0] DUTY_RESET = 8'h00;
	localparam logic [1:0]  DIV_RESET     = 2'h0;
	// Nominal base tick 102.4 kHz at 125 MHz: 1220.7 cycles, rounded down
	localparam int          CLK_KHZ       = 125000;
	localparam int          TICK_HZ       = 102400;
	localparam int          TICK_NOM_CYC  = (CLK_KHZ * 1000) / TICK_HZ;
	// Source select per channel: 0/1 generators, 2/3 parallel inputs
	localparam logic [1:0]  SRC_GEN0      = 2'h0;
	localparam logic [1:0]  SRC_GEN1      = 2'h1;
	localparam logic [1:0]  SRC_IN0       = 2'h2;
	localparam logic [1:0]  SRC_IN1       = 2'h3;
	// Trim table, tick period in clock cycles, per mille of frequency
	function automatic logic [15:0] trim_period(input logic [3:0] code,
	                                            input int         nominal);
		int pm;
		pm = 1000;
		case (code)
			4'h1: pm = 628;
			4'h2: pm = 681;
			4'h3: pm = 731;
			4'h4: pm = 790;
			4'h5: pm = 845;
			4'h6: pm = 891;
			4'h7: pm = 942;
			4'h9: pm = 1043;
			4'hA: pm = 1089;
			4'hB: pm = 1140;
			4'hC: pm = 1195;
			4'hD: pm = 1256;
			4'hE: pm = 1324;
			4'hF: pm = 1400;
			default: pm = 1000;
		endcase
		return 16'((nominal * 1000) / pm);
	endfunction
endpackage

// *** core/pwm_gen.sv ***
// Purpose: one automatic generator with period-boundary duty update
// Assumes: tick is a one-cycle pulse on mclk
// Notes: output is registered
module pwm_gen
	import pwm_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              nrst,
	input  wire logic              tick,
	input  wire logic [DUTY_W-1:0] dutySetting,
	input  wire logic [1:0]        periodDividerSelect,
	output logic                   pwmOut,
	output logic                   periodStart
);
	logic [CNT_W-1:0]  count;
	logic [DUTY_W-1:0] dutyActive;
	logic [1:0]        divActive;
	logic [CNT_W-1:0]  lastCount;
	logic [DUTY_W-1:0] scaled;
	logic              wrap;

	assign lastCount = (divActive == DIV_512) ? 10'h1FF :
	                   (divActive == DIV_256) ? 10'h0FF : 10'h3FF;
	assign wrap      = tick && (count == lastCount);
	assign scaled    = (divActive == DIV_512) ? count[8:1] :
	                   (divActive == DIV_256) ? count[7:0] : count[9:2];

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			count      <= '0;
			dutyActive <= DUTY_RESET;
			divActive  <= DIV_RESET;
			pwmOut     <= 1'b0;
			periodStart <= 1'b0;
		end else begin
			periodStart <= wrap;
			if (tick)
				count <= wrap ? '0 : count + 10'h001;
			// Settings latched only at the boundary
			if (wrap) begin
				dutyActive <= dutySetting;
				divActive  <= periodDividerSelect;
			end
			// Duty FF gives 255 of 256 steps high
			pwmOut <= (divActive == DIV_FULL_ON) || (scaled < dutyActive);
		end
	end

	period_len_a: assert property (@(posedge mclk) disable iff (!nrst)
		(tick && count == 10'h0FF && divActive == DIV_256)
		|=> count == '0) else $error("period length wrong for 256");
	full_on_a: assert property (@(posedge mclk) disable iff (!nrst)
		(divActive == DIV_FULL_ON) |=> pwmOut) else $error("full on not held");
	duty_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
		!wrap |=> $stable(dutyActive)) else $error("duty changed mid period");
	zero_duty_a: assert property (@(posedge mclk) disable iff (!nrst)
		(dutyActive == 8'h00 && divActive != DIV_FULL_ON) |=> !pwmOut)
		else $error("zero duty drove high");
	max_duty_a: assert property (@(posedge mclk) disable iff (!nrst)
		(dutyActive == 8'hFF && divActive == DIV_256 && count == 10'h0FF)
		|=> !pwmOut) else $error("max duty lacks low step");
endmodule

// *** verif/power_channels.sv ***
// Purpose: load model of the eight power output channels
// Assumes: channel outputs are active high levels on mclk
// Notes: a load only latches the level, it never drives back
module power_channels
	import pwm_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic [NUM_CHAN-1:0] chanOut,
	output logic      [NUM_CHAN-1:0] loadOn
);
	timeunit 1ns;
	timeprecision 100ps;
	always_ff @(posedge mclk) begin
		loadOn <= chanOut;
	end
endmodule

// *** verif/dual_pwm_generator_mapping_test.sv ***
// Purpose: self-checking bench for the dual generator and mapping block
// Assumes: a shortened nominal tick so whole periods fit in the run
// Notes: mapping at duty 0 first, then tick timing, then generator periods
module dual_pwm_generator_mapping_test
	import pwm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// Short tick keeps a 1024-step period near 16k cycles
	localparam int TB_TICK = 16;
	localparam int LIMIT   = 40000;
	logic mclk, nrst, baseTick;
	logic [3:0] baseTickTrim;
	logic [7:0] duty0, duty1, chanPwmEnable, chanDirect, chanOut, loadOn;
	logic [1:0] periodDiv0, periodDiv1, parallelIn, genOut;
	logic [15:0] chanSource;
	int num_errors, total_checks, n, s, hi, per, dutyRnd;
	dual_pwm_top #(.TICK_NOM(TB_TICK)) i_dut (.mclk(mclk), .nrst(nrst),
		.baseTickTrim(baseTickTrim),
		.duty0(duty0), .periodDiv0(periodDiv0), .duty1(duty1),
		.periodDiv1(periodDiv1), .chanSource(chanSource),
		.chanPwmEnable(chanPwmEnable), .chanDirect(chanDirect),
		.parallelIn(parallelIn), .chanOut(chanOut), .genOut(genOut),
		.baseTick(baseTick));
	power_channels i_load (.mclk(mclk), .chanOut(chanOut), .loadOn(loadOn));
	task automatic check(input string name, input logic [15:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Generators still at duty 0, so only pins and direct bits show
	function automatic logic [7:0] exp_map();
		logic [1:0] src;
		exp_map = 8'h00;
		for (int c = 0; c < 8; c++) begin
			src = chanSource[2*c+:2];
			exp_map[c] = !chanPwmEnable[c] ? chanDirect[c] :
				(src == 2'h2) ? parallelIn[0] : (src == 2'h3) ? parallelIn[1] : 1'b0;
		end
	endfunction
	function automatic int tick_cyc(input logic [3:0] code);
		int pm [16] = '{1000, 628, 681, 731, 790, 845, 891, 942,
			1000, 1043, 1089, 1140, 1195, 1256, 1324, 1400};
		return (TB_TICK * 1000) / pm[code];
	endfunction
	task automatic wait_tick(output int cyc);
		cyc = 0;
		do begin
			@(negedge mclk);
			cyc++;
		end while (baseTick !== 1'b1 && cyc < 4000);
	endtask
	// Wait for a rising generator output, seen at a falling edge
	task automatic sync_rise(input int g);
		int cyc;
		cyc = 0;
		while (genOut[g] !== 1'b0 && cyc < LIMIT) begin
			@(negedge mclk);
			cyc++;
		end
		while (genOut[g] !== 1'b1 && cyc < LIMIT) begin
			@(negedge mclk);
			cyc++;
		end
	endtask
	// Called at a rise; returns high time and period, ends at next rise
	task automatic measure(input int g, output int high, output int len);
		high = 0;
		len = 0;
		while (genOut[g] === 1'b1 && len < LIMIT) begin
			@(negedge mclk);
			high++;
			len++;
		end
		while (genOut[g] !== 1'b1 && len < LIMIT) begin
			@(negedge mclk);
			len++;
		end
	endtask
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		repeat (95000) @(posedge mclk);
		num_errors++;
		final_report();
	end
	initial begin
		{nrst, duty0, duty1, periodDiv0, periodDiv1} = '0;
		{chanSource, chanPwmEnable, chanDirect, parallelIn} = '0;
		baseTickTrim = TRIM_NOMINAL;
		s = $urandom(40239);
		repeat (2) @(posedge mclk);
		@(negedge mclk) nrst = 1'b1;
		check("chanOut", chanOut, 16'h0);
		check("genOut", genOut, 16'h0);
		// Mid-period writes must wait for the wrap
		duty0 = 8'hFF;
		periodDiv0 = DIV_FULL_ON;
		duty1 = 8'h80;
		periodDiv1 = DIV_256;
		for (int i = 0; i < 24; i++) begin
			@(negedge mclk);
			chanSource = (i == 0) ? 16'hFFFF : (i == 1) ? 16'hAAAA : 16'($urandom);
			chanPwmEnable = (i < 2) ? 8'hFF : 8'($urandom);
			chanDirect = 8'($urandom);
			parallelIn = (i == 0) ? 2'h2 : 2'($urandom);
			repeat (6) @(negedge mclk);
			check("loadOn", loadOn, exp_map());
			check("genOut", genOut, 16'h0);
		end
		for (int code = 0; code < 16; code++) begin
			@(negedge mclk) baseTickTrim = code[3:0];
			wait_tick(n);
			wait_tick(n);
			wait_tick(n);
			check("tickCycles", n[15:0], 16'(tick_cyc(code[3:0])));
		end
		// Generator phase: channel 0 on gen0, the rest on gen1
		@(negedge mclk);
		baseTickTrim = TRIM_NOMINAL;
		chanPwmEnable = 8'hFF;
		chanSource = 16'h5554;
		sync_rise(1);
		check("genOut0", genOut[0], 16'h1);
		// Written just after the boundary, must wait a whole period
		duty1 = 8'h40;
		measure(1, hi, per);
		check("highOld", 16'(hi), 16'(8'h80 * TB_TICK));
		check("chanOut", chanOut, 16'hFF);
		measure(1, hi, per);
		check("high256", 16'(hi), 16'(8'h40 * TB_TICK));
		check("period256", 16'(per), 16'(256 * TB_TICK));
		duty1 = 8'hFF;
		measure(1, hi, per);
		check("highOld", 16'(hi), 16'(8'h40 * TB_TICK));
		dutyRnd = $urandom_range(254, 1);
		duty1 = 8'(dutyRnd);
		periodDiv1 = DIV_512;
		duty0 = 8'h00;
		periodDiv0 = DIV_256;
		check("genOut0", genOut[0], 16'h1);
		measure(1, hi, per);
		check("highMax", 16'(hi), 16'(255 * TB_TICK));
		check("period256", 16'(per), 16'(256 * TB_TICK));
		measure(1, hi, per);
		check("high512", 16'(hi), 16'(2 * dutyRnd * TB_TICK));
		check("period512", 16'(per), 16'(512 * TB_TICK));
		check("genOut0", genOut[0], 16'h0);
		check("chanOut", chanOut, 16'hFE);
		n = dutyRnd;
		dutyRnd = $urandom_range(254, 1);
		duty1 = 8'(dutyRnd);
		periodDiv1 = DIV_1024;
		measure(1, hi, per);
		check("highOld", 16'(hi), 16'(2 * n * TB_TICK));
		check("periodOld", 16'(per), 16'(512 * TB_TICK));
		measure(1, hi, per);
		check("high1024", 16'(hi), 16'(4 * dutyRnd * TB_TICK));
		check("period1024", 16'(per), 16'(1024 * TB_TICK));
		check("genOut0", genOut[0], 16'h0);
		final_report();
	end
endmodule
